// >>> hw/gpr_file.sv
// General-purpose register file with mode-aware aliasing and result-width handling
`timescale 1ns/100ps
`include "gpr_regs.svh"
// ----------------------------------------------------------------
// Summary of operation
// - Legacy modes offer eight 32-bit registers, accumulator through destination index.
// - Low 16 bits of each legacy register read and write as a word alias.
// - First four registers expose bits 7..0 and 15..8 as byte aliases.
// - 64-bit mode offers sixteen 64-bit registers, default operand size 32.
// - In 64-bit mode all sixteen registers allow byte, word, dword, qword access.
// - Qword size and registers eight to fifteen need the extension prefix.
// - Byte selectors pick legacy low/high bytes, or all sixteen low bytes with prefix.
// - With prefix, high-byte selectors map to pointer and index low bytes.
// - 64-bit operations write all 64 destination bits.
// - 32-bit operations in 64-bit mode zero the upper 32 destination bits.
// - 8- and 16-bit operations leave upper 56 or 48 bits unchanged.
// - Extended registers survive a round trip through compatibility mode.
// - Passing on into legacy or real mode may lose extended register contents.
// - Upper 32 bits of all registers need not survive leaving 64-bit mode.
// - A 32-bit next instruction pointer is held for legacy modes.
// - String operations read counter, source and destination dwords implicitly.
// ----------------------------------------------------------------
module gpr_file (
  // Clock and reset
  input  wire logic                                         clk,
  input  wire logic                                         sys_rst,
  // Operating mode from the core
  input  wire gpr_pkg::mode_t                               mode,
  // Operand read ports
  input  wire logic    [`GPR_RD_PORTS-1:0][`GPR_SEL_W-1:0]  rd_sel,
  input  wire gpr_pkg::opsize_t [`GPR_RD_PORTS-1:0]         rd_size,
  input  wire logic    [`GPR_RD_PORTS-1:0]                  rd_pfx,
  output logic         [`GPR_RD_PORTS-1:0][`GPR_WIDTH-1:0]  rd_data,
  output logic         [`GPR_RD_PORTS-1:0]                  rd_fault,
  // Result write port
  input  wire logic                                         wr_en,
  input  wire logic    [`GPR_SEL_W-1:0]                     wr_sel,
  input  wire gpr_pkg::opsize_t                             wr_size,
  input  wire logic                                         wr_pfx,
  input  wire logic    [`GPR_WIDTH-1:0]                     wr_data,
  output logic                                              wr_fault,
  // Implicit string operands
  output logic         [`GPR_LEGACY_WIDTH-1:0]              str_counter_dword,
  output logic         [`GPR_LEGACY_WIDTH-1:0]              str_source_dword,
  output logic         [`GPR_LEGACY_WIDTH-1:0]              str_dest_dword,
  // Instruction pointer
  input  wire logic                                         ip_load,
  input  wire logic    [`GPR_LEGACY_WIDTH-1:0]              ip_value,
  output logic         [`GPR_LEGACY_WIDTH-1:0]              next_instr_pointer,
  // Notice to the vector unit that upper vector state is gone
  output logic                                              ext_ctx_lost
);
  import gpr_pkg::*;

  localparam int NP = `GPR_RD_PORTS;
  localparam int W  = `GPR_WIDTH;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  gpr_store_if #(
    .DEPTH (`GPR_NUM_LONG),
    .WIDTH (`GPR_WIDTH),
    .NRD   (`GPR_STORE_RD)
  ) st ();

  gpr_storage #(
    .DEPTH (`GPR_NUM_LONG),
    .WIDTH (`GPR_WIDTH),
    .NRD   (`GPR_STORE_RD)
  ) u_storage (
    .clk     (clk),
    .sys_rst (sys_rst),
    .bus     (st.store)
  );

  // ----------------------------------------------------------------
  // Selector decode
  // ----------------------------------------------------------------
  // Maps selector, size and prefix onto a physical register and view
  function automatic access_t decode(input logic [3:0] sel, input opsize_t size,
                                     input logic pfx, input mode_t md);
    access_t a;
    logic    long_m;
    long_m    = (md == MODE_LONG);
    a.size    = size;
    a.idx     = sel;                              // with prefix: low byte of any of sixteen
    a.hi_byte = 1'b0;
    // Without prefix selectors 4..7 name the high bytes of the first four
    if (size == OP_BYTE && !pfx && sel[2]) begin
      a.hi_byte = 1'b1;
      a.idx     = {2'b00, sel[1:0]};
    end
    // With prefix those same selectors stay as pointer/index low bytes
    // Legacy modes know no prefix, no qword and only eight registers
    a.fault = (!long_m && (pfx || sel[3] || size == OP_QWORD))
            || (!pfx && (sel[3] || size == OP_QWORD));
    return a;
  endfunction : decode

  // Cuts the addressed view out of a full register, zero-extended
  function automatic logic [W-1:0] view(input logic [W-1:0] w, input access_t a);
    logic [W-1:0] v;
    v = '0;
    if (!a.fault) begin
      case (a.size)
        OP_BYTE:  v = a.hi_byte ? {56'h0, w[15:8]} : {56'h0, w[7:0]};
        OP_WORD:  v = {48'h0, w[15:0]};
        OP_DWORD: v = {32'h0, w[31:0]};
        OP_QWORD: v = w;
        default:  v = '0;
      endcase
    end
    return v;
  endfunction : view

  // ----------------------------------------------------------------
  // Read path: decode, storage read, view register
  // ----------------------------------------------------------------
  access_t [NP-1:0]        acc_q, acc_d;
  logic    [NP-1:0][W-1:0] rdat_q, rdat_d;
  logic    [NP-1:0]        rflt_q, rflt_d;

  // Two stages for every view, so narrow and full reads align
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      acc_d[p]     = decode(rd_sel[p], rd_size[p], rd_pfx[p], mode);
      st.rd_idx[p] = acc_d[p].idx;
      rdat_d[p]    = view(st.rd_data[p], acc_q[p]);
      rflt_d[p]    = acc_q[p].fault;
    end
    // Implicit operands have ports of their own, no selector needed
    st.rd_idx[NP]   = `SEL_COUNTER;
    st.rd_idx[NP+1] = `SEL_SOURCE;
    st.rd_idx[NP+2] = `SEL_DEST;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q  <= '0;
      rdat_q <= '0;
      rflt_q <= '0;
    end else begin
      acc_q  <= acc_d;
      rdat_q <= rdat_d;
      rflt_q <= rflt_d;
    end
  end

  assign rd_data  = rdat_q;
  assign rd_fault = rflt_q;

  // String operands come straight from storage read registers
  assign str_counter_dword = st.rd_data[NP][31:0];
  assign str_source_dword  = st.rd_data[NP+1][31:0];
  assign str_dest_dword    = st.rd_data[NP+2][31:0];

  // ----------------------------------------------------------------
  // Write path: result width sets the mask
  // ----------------------------------------------------------------
  access_t wacc;
  logic    wflt_q, wflt_d;

  always_comb begin
    wacc       = decode(wr_sel, wr_size, wr_pfx, mode);
    st.wr_en   = wr_en && !wacc.fault;   // faulting writes are dropped
    st.wr_idx  = wacc.idx;
    st.wr_mask = '0;
    st.wr_data = '0;
    case (wacc.size)
      OP_BYTE: begin
        if (wacc.hi_byte) begin
          st.wr_mask = 64'h0000_0000_0000_FF00;
          st.wr_data = {48'h0, wr_data[7:0], 8'h00};
        end else begin
          st.wr_mask = 64'h0000_0000_0000_00FF;
          st.wr_data = {56'h0, wr_data[7:0]};
        end
      end
      OP_WORD: begin
        st.wr_mask = 64'h0000_0000_0000_FFFF;
        st.wr_data = {48'h0, wr_data[15:0]};
      end
      OP_DWORD: begin
        // Zero-extension also applied in legacy modes, upper half is unused there
        st.wr_mask = 64'hFFFF_FFFF_FFFF_FFFF;
        st.wr_data = {32'h0, wr_data[31:0]};
      end
      OP_QWORD: begin
        st.wr_mask = 64'hFFFF_FFFF_FFFF_FFFF;
        st.wr_data = wr_data;
      end
      default: begin
        st.wr_mask = '0;
        st.wr_data = '0;
      end
    endcase
    wflt_d = wr_en && wacc.fault;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wflt_q <= 1'b0;
    end else begin
      wflt_q <= wflt_d;
    end
  end

  assign wr_fault = wflt_q;

  // ----------------------------------------------------------------
  // Mode transitions
  // ----------------------------------------------------------------
  mode_t mode_q, mode_d;
  logic  lost_q, lost_d;
  logic  leave_long, enter_legacy;

  // Clearing rather than keeping stale bits makes the undefined cases repeatable
  always_comb begin
    mode_d       = mode;
    leave_long   = (mode_q == MODE_LONG) && (mode != MODE_LONG);
    enter_legacy = (mode == MODE_REAL || mode == MODE_PROT)
                && (mode_q == MODE_COMPAT || mode_q == MODE_LONG);
    // Upper halves of the eight legacy registers dropped on leaving 64-bit mode
    st.clr_upper = leave_long ? `MASK_LEGACY_REGS : 16'h0000;
    // Extended registers kept through compatibility, wiped on reaching legacy
    st.clr_all   = enter_legacy ? `MASK_EXT_REGS : 16'h0000;
    lost_d       = enter_legacy;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= MODE_REAL;
      lost_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      lost_q <= lost_d;
    end
  end

  assign ext_ctx_lost = lost_q;

  // ----------------------------------------------------------------
  // Next instruction pointer
  // ----------------------------------------------------------------
  logic [`GPR_LEGACY_WIDTH-1:0] ip_q, ip_d;

  always_comb begin
    ip_d = ip_load ? ip_value : ip_q;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ip_q <= `IP_RESET_VALUE;
    end else begin
      ip_q <= ip_d;
    end
  end

  assign next_instr_pointer = ip_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [7:0] st_hi_byte0;
  assign st_hi_byte0 = st.rd_data[0][15:8];

  a_qword_needs_pfx: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_size[0] == OP_QWORD && !rd_pfx[0]) |-> ##2 (rd_fault[0] && rd_data[0] == '0))
    else $error("qword read without prefix not refused");

  a_ext_sel_legacy: assert property (@(posedge clk) disable iff (sys_rst)
    (mode != MODE_LONG && rd_sel[0][3]) |-> ##2 rd_fault[0])
    else $error("extended register reached outside 64-bit mode");

  a_hi_byte_view: assert property (@(posedge clk) disable iff (sys_rst)
    (mode == MODE_LONG && rd_size[0] == OP_BYTE && !rd_pfx[0] && rd_sel[0][2] && !rd_sel[0][3])
    |-> ##2 (rd_data[0] == {56'h0, $past(st_hi_byte0)}))
    else $error("high byte view wrong");

  a_pfx_byte_remap: assert property (@(posedge clk) disable iff (sys_rst)
    (mode == MODE_LONG && rd_size[0] == OP_BYTE && rd_pfx[0]) |-> st.rd_idx[0] == rd_sel[0])
    else $error("prefixed byte selector not remapped to low byte");

  a_dword_zero_ext: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_en && mode == MODE_LONG && wr_size == OP_DWORD && !(wr_sel[3] && !wr_pfx))
    |-> (st.wr_en && st.wr_data[63:32] == 32'h0 && st.wr_mask[63:32] == 32'hFFFF_FFFF))
    else $error("dword write does not clear upper half");

  a_wr_fault_ext: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_en && wr_sel[3] && !wr_pfx) |-> !st.wr_en ##1 wr_fault)
    else $error("unprefixed extended write not refused");

  a_ip_load: assert property (@(posedge clk) disable iff (sys_rst)
    ip_load |=> next_instr_pointer == $past(ip_value))
    else $error("instruction pointer not loaded");

  a_ctx_lost: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(mode) == MODE_COMPAT && (mode == MODE_REAL || mode == MODE_PROT)) |=> ext_ctx_lost)
    else $error("extended context loss not flagged");

endmodule : gpr_file

// >>> hw/gpr_regs.svh
// Register file constants: sizes, fixed selectors, reset values and latencies
`ifndef GPR_REGS_SVH
`define GPR_REGS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define GPR_NUM_LEGACY    8
`define GPR_NUM_LONG      16
`define GPR_WIDTH         64
`define GPR_LEGACY_WIDTH  32
`define GPR_SEL_W         4
`define GPR_RD_PORTS      2
`define GPR_STORE_RD      5

// ----------------------------------------------------------------
// Fixed register selectors (implicit operands)
// ----------------------------------------------------------------
`define SEL_COUNTER       4'h1
`define SEL_SOURCE        4'h6
`define SEL_DEST          4'h7
`define SEL_FIRST_EXT     4'h8

// ----------------------------------------------------------------
// Masks over the register index space
// ----------------------------------------------------------------
`define MASK_LEGACY_REGS  16'h00FF
`define MASK_EXT_REGS     16'hFF00

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define GPR_RESET_VALUE   64'h0000_0000_0000_0000
`define IP_RESET_VALUE    32'h0000_0000
`define READ_LATENCY      2

`endif

// >>> hw/gpr_pkg.sv
// Types shared by the register file and its storage
package gpr_pkg;

  // ----------------------------------------------------------------
  // Operating modes and operand sizes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_REAL, MODE_PROT, MODE_COMPAT, MODE_LONG} mode_t;
  typedef enum logic [1:0] {OP_BYTE, OP_WORD, OP_DWORD, OP_QWORD} opsize_t;

  // Decoded access: physical index plus view
  typedef struct packed {
    logic [3:0] idx;
    logic       hi_byte;
    opsize_t    size;
    logic       fault;
  } access_t;

endpackage : gpr_pkg

// >>> hw/gpr_store_if.sv
// Connection between the register file control and its storage array
`timescale 1ns/100ps
interface gpr_store_if #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 64,
  parameter int NRD   = 5
);
  localparam int IW = $clog2(DEPTH);

  // Write port with bit mask, bulk clears, read ports
  logic                      wr_en;
  logic [IW-1:0]             wr_idx;
  logic [WIDTH-1:0]          wr_mask;
  logic [WIDTH-1:0]          wr_data;
  logic [DEPTH-1:0]          clr_upper;
  logic [DEPTH-1:0]          clr_all;
  logic [NRD-1:0][IW-1:0]    rd_idx;
  logic [NRD-1:0][WIDTH-1:0] rd_data;

  modport ctrl  (output wr_en, wr_idx, wr_mask, wr_data, clr_upper, clr_all, rd_idx, input rd_data);
  modport store (input wr_en, wr_idx, wr_mask, wr_data, clr_upper, clr_all, rd_idx, output rd_data);
endinterface : gpr_store_if

// >>> hw/gpr_storage.sv
// Register storage array with masked write, bulk clears and registered reads
`timescale 1ns/100ps
`include "gpr_regs.svh"
module gpr_storage #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 64,
  parameter int NRD   = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Access from the control side
  gpr_store_if.store bus
);
  import gpr_pkg::*;

  localparam int IW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DEPTH != `GPR_NUM_LONG || WIDTH != `GPR_WIDTH) begin : g_bad_geom
    $error("gpr_storage geometry must be 16 x 64");
  end

  logic [DEPTH-1:0][WIDTH-1:0] mem_q, mem_d;
  logic [NRD-1:0][WIDTH-1:0]   rd_q, rd_d;

  // ----------------------------------------------------------------
  // Next state: clears first, a write in the same cycle lands on top
  // ----------------------------------------------------------------
  always_comb begin
    mem_d = mem_q;
    for (int i = 0; i < DEPTH; i++) begin
      if (bus.clr_all[i]) begin
        mem_d[i] = '0;
      end else if (bus.clr_upper[i]) begin
        mem_d[i][WIDTH-1:WIDTH/2] = '0;
      end
      // Only the masked bits move, so narrow views keep the rest
      if (bus.wr_en && bus.wr_idx == IW'(i)) begin
        mem_d[i] = (mem_d[i] & ~bus.wr_mask) | (bus.wr_data & bus.wr_mask);
      end
    end
    // Read before write: a same-cycle write shows one cycle later
    for (int k = 0; k < NRD; k++) begin
      rd_d[k] = mem_q[bus.rd_idx[k]];
    end
  end

  // Register state and read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_q <= {DEPTH{`GPR_RESET_VALUE}};
      rd_q  <= '0;
    end else begin
      mem_q <= mem_d;
      rd_q  <= rd_d;
    end
  end

  assign bus.rd_data = rd_q;

  // Extended register survives any cycle without a clear or write
  a_ext_reg_retained: assert property (@(posedge clk) disable iff (sys_rst)
    (!bus.clr_all[`SEL_FIRST_EXT] && !(bus.wr_en && bus.wr_idx == `SEL_FIRST_EXT))
    |=> mem_q[`SEL_FIRST_EXT] == $past(mem_q[`SEL_FIRST_EXT]))
    else $error("extended register changed without write or clear");

endmodule : gpr_storage

// >>> tb/exec_datapath_model.sv
// Behavioural decode and execute side that issues register file requests
`timescale 1ns/100ps
module exec_datapath_model (
  // Clock
  input  wire logic                    clk,
  // Mode and operand reads
  output gpr_pkg::mode_t               mode,
  output logic [1:0][3:0]              rd_sel,
  output gpr_pkg::opsize_t [1:0]       rd_size,
  output logic [1:0]                   rd_pfx,
  output logic [1:0]                   rd_on,
  // Result write and pointer load
  output logic                         wr_en,
  output logic [3:0]                   wr_sel,
  output gpr_pkg::opsize_t             wr_size,
  output logic                         wr_pfx,
  output logic [63:0]                  wr_data,
  output logic                         ip_load,
  output logic [31:0]                  ip_value
);
  import gpr_pkg::*;

  // Quiet request lines from time zero
  initial begin
    mode = MODE_REAL;
    rd_size[0] = OP_BYTE;
    rd_size[1] = OP_BYTE;
    wr_size = OP_BYTE;
    {rd_sel, rd_pfx, rd_on, wr_en, wr_sel, wr_pfx, wr_data, ip_load, ip_value} = '0;
  end

  // ----------------------------------------------------------------
  // Request tasks: each owns one cycle, changed just after an edge
  // ----------------------------------------------------------------
  // Unused read selectors and write data flip so stale values never look valid
  task automatic write(input logic [3:0] s, input opsize_t z, input logic x, input logic [63:0] d);
    @(posedge clk);
    {wr_en, wr_sel, wr_pfx, wr_data, rd_on, rd_sel, ip_load} <= {1'h1, s, x, d, 2'h0, ~rd_sel, 1'h0};
    wr_size <= z;
  endtask : write

  task automatic read2(input logic [3:0] s0, s1, input opsize_t z0, z1, input logic [1:0] x);
    @(posedge clk);
    {rd_sel, rd_pfx, rd_on, wr_en, wr_data, ip_load} <= {s1, s0, x, 2'h3, 1'h0, ~wr_data, 1'h0};
    rd_size[0] <= z0;
    rd_size[1] <= z1;
  endtask : read2

  task automatic set_mode(input mode_t m);
    @(posedge clk);
    mode <= m;
    {rd_on, rd_sel, wr_en, wr_data, ip_load} <= {2'h0, ~rd_sel, 1'h0, ~wr_data, 1'h0};
  endtask : set_mode

  task automatic load_ip(input logic [31:0] v);
    @(posedge clk);
    {rd_on, rd_sel, wr_en, wr_data, ip_load, ip_value} <= {2'h0, ~rd_sel, 1'h0, ~wr_data, 1'h1, v};
  endtask : load_ip

  task automatic idle();
    @(posedge clk);
    {rd_on, rd_sel, wr_en, wr_data, ip_load} <= {2'h0, ~rd_sel, 1'h0, ~wr_data, 1'h0};
  endtask : idle
endmodule : exec_datapath_model

// >>> tb/general_purpose_register_file_tb_top.sv
// Self-checking bench for the general-purpose register file
`timescale 1ns/100ps
`include "gpr_regs.svh"
module general_purpose_register_file_tb_top;
  import gpr_pkg::*;

  // ----------------------------------------------------------------
  // Clock, reset and wiring
  // ----------------------------------------------------------------
  logic             clk = 1'h0;
  logic             sys_rst = 1'h1;
  mode_t            mode;
  logic [1:0][3:0]  rd_sel;
  opsize_t [1:0]    rd_size;
  logic [1:0]       rd_pfx, rd_on, rd_fault;
  logic [1:0][63:0] rd_data;
  logic             wr_en, wr_pfx, wr_fault, ip_load, ext_ctx_lost;
  logic [3:0]       wr_sel;
  opsize_t          wr_size;
  logic [63:0]      wr_data;
  logic [31:0]      ip_value, next_instr_pointer, str_counter_dword, str_source_dword, str_dest_dword;
  // Scoreboard state
  logic [63:0]      shadow [16] = '{default: 64'h0};
  mode_t            cur_md = MODE_REAL;
  logic [31:0]      ip_ref = 32'h0;
  logic [31:0]      r;
  logic [64:0]      q0 [$], q1 [$], wfq [$];
  logic [1:0][1:0]  rp = '0;
  logic             wp = 1'h0;
  int               n_fail = 0;
  int               checks = 0;
  integer           seed = 32'h492962a4;

  always #25 clk = ~clk;

  gpr_file uut (.clk, .sys_rst, .mode, .rd_sel, .rd_size, .rd_pfx, .rd_data, .rd_fault, .wr_en, .wr_sel,
    .wr_size, .wr_pfx, .wr_data, .wr_fault, .str_counter_dword, .str_source_dword, .str_dest_dword,
    .ip_load, .ip_value, .next_instr_pointer, .ext_ctx_lost);

  exec_datapath_model dp (.clk, .mode, .rd_sel, .rd_size, .rd_pfx, .rd_on, .wr_en, .wr_sel, .wr_size,
    .wr_pfx, .wr_data, .ip_load, .ip_value);

  // ----------------------------------------------------------------
  // Comparison, verdict and reference model
  // ----------------------------------------------------------------
  task automatic check(input logic [64:0] seen, input logic [64:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // Prefix outside 64-bit mode, or wide/extended access without it, is refused
  function automatic logic is_fault(input logic [3:0] s, input opsize_t z, input logic x);
    return (x && cur_md != MODE_LONG) || (!x && (s[3] || z == OP_QWORD));
  endfunction : is_fault

  function automatic logic [64:0] exp_rd(input logic [3:0] s, input opsize_t z, input logic x);
    logic [63:0] v;
    v = shadow[s];
    if (is_fault(s, z, x)) return {1'h1, 64'h0};
    case (z)
      OP_BYTE:  v = (!x && s[2]) ? 64'(shadow[{2'h0, s[1:0]}][15:8]) : 64'(v[7:0]);
      OP_WORD:  v = 64'(v[15:0]);
      OP_DWORD: v = 64'(v[31:0]);
      default:  v = v;
    endcase
    return {1'h0, v};
  endfunction : exp_rd

  // Answers stand two edges after the edge that drives a read, one after a write
  always @(posedge clk) begin
    rp <= {rp[0], rd_on};
    wp <= wr_en;
  end

  always @(negedge clk) begin
    if (rp[1][0]) check({rd_fault[0], rd_data[0]}, q0.pop_front());
    if (rp[1][1]) check({rd_fault[1], rd_data[1]}, q1.pop_front());
    check({64'h0, wr_fault}, wp ? wfq.pop_front() : 65'h0);
  end

  // ----------------------------------------------------------------
  // Driver tasks that note expectations before issuing
  // ----------------------------------------------------------------
  task automatic bwrite(input logic [3:0] s, input opsize_t z, input logic x, input logic [63:0] d);
    logic f;
    f = is_fault(s, z, x);
    wfq.push_back({64'h0, f});
    if (!f) begin
      case (z)
        OP_BYTE:  if (!x && s[2]) shadow[{2'h0, s[1:0]}][15:8] = d[7:0]; else shadow[s][7:0] = d[7:0];
        OP_WORD:  shadow[s][15:0] = d[15:0];
        OP_DWORD: shadow[s] = {32'h0, d[31:0]};
        default:  shadow[s] = d;
      endcase
    end
    dp.write(s, z, x, d);
  endtask : bwrite

  task automatic bread(input logic [3:0] s0, s1, input opsize_t z0, z1, input logic [1:0] x);
    q0.push_back(exp_rd(s0, z0, x[0]));
    q1.push_back(exp_rd(s1, z1, x[1]));
    dp.read2(s0, s1, z0, z1, x);
  endtask : bread

  // Undefined upper halves and extended registers are taken as cleared
  task automatic bmode(input mode_t m);
    logic lost;
    lost = (cur_md inside {MODE_COMPAT, MODE_LONG}) && (m inside {MODE_REAL, MODE_PROT});
    if (cur_md == MODE_LONG && m != MODE_LONG) for (int i = 0; i < 8; i++) shadow[i][63:32] = 32'h0;
    if (lost) for (int i = 8; i < 16; i++) shadow[i] = 64'h0;
    cur_md = m;
    dp.set_mode(m);
    @(posedge clk);
    @(negedge clk);
    check({64'h0, ext_ctx_lost}, {64'h0, lost});
  endtask : bmode

  task automatic read_all();
    // Prefix only in 64-bit mode, so legacy views are really read back
    for (int i = 0; i < 16; i++) bread(4'(i), 4'(i), OP_QWORD, opsize_t'(i % 4), {2{cur_md == MODE_LONG}});
  endtask : read_all

  task automatic bip_str(input logic [31:0] v);
    ip_ref = v;
    dp.load_ip(v);
    dp.idle();
    dp.idle();
    @(negedge clk);
    check(65'(next_instr_pointer), 65'(ip_ref));
    check(65'(str_counter_dword), 65'(shadow[`SEL_COUNTER][31:0]));
    check(65'(str_source_dword), 65'(shadow[`SEL_SOURCE][31:0]));
    check(65'(str_dest_dword), 65'(shadow[`SEL_DEST][31:0]));
  endtask : bip_str

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'h0;
    bip_str(32'h0);
    // Legacy aliases and refusals
    bwrite(4'h0, OP_DWORD, 1'h0, 64'hFFFF_FFFF_8765_4321);
    bwrite(4'h4, OP_BYTE, 1'h0, 64'h0000_0000_0000_00A5);
    bread(4'h0, 4'h0, OP_WORD, OP_DWORD, 2'h0);
    bread(4'h4, 4'h0, OP_BYTE, OP_BYTE, 2'h0);
    bread(4'h7, 4'h8, OP_BYTE, OP_DWORD, 2'h0);
    bread(4'h1, 4'h0, OP_DWORD, OP_QWORD, 2'h1);
    bwrite(4'h9, OP_QWORD, 1'h1, 64'h0000_0000_0000_0001);
    for (int i = 0; i < 8; i++) bwrite(4'(i), OP_DWORD, 1'h0, {$random(seed), $random(seed)});
    read_all();
    // 64-bit mode views and result widths
    bmode(MODE_LONG);
    for (int i = 0; i < 16; i++) bwrite(4'(i), OP_QWORD, 1'h1, {$random(seed), $random(seed)});
    read_all();
    for (int i = 0; i < 8; i++) bread(4'(i), 4'(i), OP_BYTE, OP_BYTE, 2'h2);
    bread(4'h2, 4'h9, OP_DWORD, OP_DWORD, 2'h0);
    bwrite(4'h9, OP_DWORD, 1'h1, 64'hFFFF_FFFF_FFFF_FFFF);
    bwrite(4'hA, OP_BYTE, 1'h1, 64'h0000_0000_0000_005A);
    bwrite(4'hB, OP_WORD, 1'h1, 64'h0000_0000_0000_C3C3);
    bwrite(4'h5, OP_BYTE, 1'h0, 64'h0000_0000_0000_003C);
    read_all();
    // Mode round trips
    bmode(MODE_COMPAT);
    bmode(MODE_LONG);
    read_all();
    bmode(MODE_COMPAT);
    bmode(MODE_PROT);
    bmode(MODE_LONG);
    read_all();
    bip_str(32'h1234_5678);
    // Random back-to-back traffic with occasional mode switches
    for (int n = 0; n < 400; n++) begin
      r = $random(seed);
      if (n % 80 == 79) bmode(mode_t'(r[9:8]));
      else if (r[0]) bwrite(r[7:4], opsize_t'(r[3:2]), |r[11:10], {$random(seed), $random(seed)});
      else bread(r[7:4], r[15:12], opsize_t'(r[3:2]), opsize_t'(r[17:16]), r[19:18] | r[21:20]);
    end
    bip_str(32'($random(seed)));
    repeat (4) dp.idle();
    check(65'(q0.size() + q1.size() + wfq.size()), 65'h0);
    tally_and_finish();
  end

  // Watchdog: about 5000 cycles, several times the expected run
  initial begin
    #250_000;
    n_fail++;
    tally_and_finish();
  end
endmodule : general_purpose_register_file_tb_top
